// *** inc/vout_telemetry_pkg.sv ***
// Register map, field layout, reset values and timing for the voltage target block
package vout_telemetry_pkg;
    localparam int          NUM_CH          = 2;
    localparam int          CFG_N           = 19;
    localparam logic [7:0]  CFG_N_A         = 8'h13;
    // Paged configuration words, index equals byte offset
    localparam logic [4:0]  CFG_VOUT_CMD    = 5'h00;
    localparam logic [4:0]  CFG_TRIM        = 5'h01;
    localparam logic [4:0]  CFG_MARGIN_HIGH = 5'h02;
    localparam logic [4:0]  CFG_MARGIN_LOW  = 5'h03;
    localparam logic [4:0]  CFG_VOUT_MAX    = 5'h04;
    localparam logic [4:0]  CFG_VOUT_MIN    = 5'h05;
    localparam logic [4:0]  CFG_TRANS_RATE  = 5'h06;
    localparam logic [4:0]  CFG_SCALE_LOOP  = 5'h07;
    localparam logic [4:0]  CFG_TON_RISE    = 5'h08;
    localparam logic [4:0]  CFG_TOFF_FALL   = 5'h09;
    localparam logic [4:0]  CFG_LL_NOM      = 5'h0a;
    localparam logic [4:0]  CFG_OFS_NOM     = 5'h0b;
    localparam logic [4:0]  CFG_LL_UP       = 5'h0c;
    localparam logic [4:0]  CFG_LL_DOWN     = 5'h0d;
    localparam logic [4:0]  CFG_OFS_UP      = 5'h0e;
    localparam logic [4:0]  CFG_OFS_DOWN    = 5'h0f;
    localparam logic [4:0]  CFG_REC_DELAY   = 5'h10;
    localparam logic [4:0]  CFG_CAL_GAIN    = 5'h11;
    localparam logic [4:0]  CFG_PH_ACTIVE   = 5'h12;
    // Other registers
    localparam logic [7:0]  REG_PAGE        = 8'h20;
    localparam logic [7:0]  REG_PHASE       = 8'h21;
    localparam logic [7:0]  REG_OPERATION   = 8'h22;
    localparam logic [7:0]  REG_CAL_OFFSET  = 8'h23;
    localparam logic [7:0]  REG_READ_IOUT   = 8'h24;
    localparam logic [7:0]  REG_STATUS      = 8'h25;
    localparam logic [7:0]  REG_PRESENT     = 8'h26;
    // Operation byte layout and margin codes
    localparam int          OP_ON_BIT       = 7;
    localparam int          MARGIN_MSB      = 5;
    localparam int          MARGIN_LSB      = 2;
    localparam logic [3:0]  MARGIN_NONE     = 4'h0;
    localparam logic [3:0]  MARGIN_LOW_ACT  = 4'h5;
    localparam logic [3:0]  MARGIN_LOW_IGN  = 4'h6;
    localparam logic [3:0]  MARGIN_HIGH_ACT = 4'h9;
    localparam logic [3:0]  MARGIN_HIGH_IGN = 4'ha;
    localparam logic [7:0]  PHASE_TOTAL     = 8'hff;
    // Current telemetry in 1/16 A, span -10 A to 70 A per phase
    localparam logic signed [15:0] IOUT_MIN = -16'sd160;
    localparam logic signed [15:0] IOUT_MAX = 16'sd1120;
    // Reset values
    localparam logic [15:0] RST_VOUT_MAX    = 16'h157c;
    localparam logic [15:0] RST_SCALE       = 16'h0100;
    localparam logic [15:0] RST_GAIN        = 16'h0100;
    localparam logic [15:0] RST_TON_RISE    = 16'h0010;
    localparam logic [15:0] RST_TOFF_FALL   = 16'h0010;
    localparam logic [15:0] RST_TRANS_RATE  = 16'h0001;
    localparam logic [15:0] RST_PH_ACTIVE   = 16'h000f;
    // Ramp tick
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          TICK_NS         = 1000;
    localparam int          TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {CH_OFF, CH_RISE, CH_ON, CH_FALL} ch_state_t;
endpackage : vout_telemetry_pkg

// *** design/vout_target_margin_telemetry.sv ***
// Voltage target selection, slewing, transition load line and output current telemetry
// Function
// - Accept new command any time, keep converting
// - Clamp combined target between minimum and maximum
// - Soft ramps from target and rise/fall times
// - Running changes slew at transition rate
// - Scale loop factor applied to voltage values
// - Trim added to target in every state
// - Transition load lines only during transitions
// - Recovery delay counted in order-0 PWM cycles
// - Margin codes none, low, high with faults
// - Ignore-fault margin codes disable fault detection
// - Phase FFh reads channel total current
// - Phase index reads that phase's current
// - One gain per channel for all phases
// - Per-phase offsets, channel offset is the sum over active phases
// - Reference subtracted from sense before gain
// - Per-phase reading spans -10 to 70 A
// - No correction stage on other telemetry
module vout_target_margin_telemetry
    import vout_telemetry_pkg::*;
#(
    parameter int NPH        = 4,
    parameter int SW         = 12,
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input  wire logic                              clock,
    input  wire logic                              reset,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic [15:0]                       reg_wdata,
    input  wire logic                              reg_write,
    input  wire logic                              reg_read,
    output logic      [15:0]                       reg_rdata,
    input  wire logic [NUM_CH-1:0]                 pwm_order0,
    input  wire logic [NUM_CH*NPH-1:0][SW-1:0]     phase_current_sense_input,
    input  wire logic [SW-1:0]                     vref_sample,
    output logic      [NUM_CH-1:0][15:0]           vout_target,
    output logic      [NUM_CH-1:0]                 fault_detect_enable,
    output logic      [NUM_CH-1:0][15:0]           loadline,
    output logic      [NUM_CH-1:0][15:0]           loadline_offset,
    output logic      [NUM_CH-1:0]                 dynamic_voltage_move
);
    localparam int PW = (NPH > 1) ? $clog2(NPH) : 1;

    typedef struct packed {
        logic [7:0]                         page;
        logic [7:0]                         phase;
        logic [NUM_CH-1:0][CFG_N-1:0][15:0] cfg;
        logic [NUM_CH-1:0][7:0]             operation;
        logic [NUM_CH-1:0][NPH-1:0][15:0]   cal_off;
        logic [NUM_CH-1:0]                  bad_margin;
        logic [15:0]                        rdata;
        logic [15:0]                        tick_cnt;
        logic                               tick;
        logic [NUM_CH-1:0]                  pwm_s1;
        logic [NUM_CH-1:0]                  pwm_s2;
        logic [NUM_CH-1:0]                  pwm_prev;
        ch_state_t [NUM_CH-1:0]             st;
        logic [NUM_CH-1:0][15:0]            present;
        logic [NUM_CH-1:0][15:0]            step;
        logic [NUM_CH-1:0][15:0]            rec_cnt;
        logic [NUM_CH-1:0][15:0]            vout;
        logic [NUM_CH-1:0][15:0]            ll;
        logic [NUM_CH-1:0][15:0]            llofs;
        logic [NUM_CH-1:0]                  moving;
        logic [NUM_CH-1:0]                  dir_up;
        logic [NUM_CH-1:0]                  dyn;
        logic [NUM_CH-1:0]                  fault_en;
        logic [NUM_CH-1:0][NPH-1:0][15:0]   iphase;
        logic [NUM_CH-1:0][15:0]            itotal;
    } state_t;

    state_t                     s;
    state_t                     next;
    logic                       pg;
    logic [NUM_CH-1:0]          pwm_edge;
    logic [NUM_CH-1:0][15:0]    sel_t;
    logic [NUM_CH-1:0][15:0]    eff;
    logic [NUM_CH-1:0][15:0]    rise_step;
    logic [NUM_CH-1:0][15:0]    fall_step;
    logic [NUM_CH-1:0][31:0]    vprod;
    logic signed [17:0]         eff_raw [NUM_CH];
    logic signed [19:0]         sum_i   [NUM_CH];
    logic signed [19:0]         sum_o   [NUM_CH];
    logic signed [15:0]         scaled;

    function automatic logic [15:0] approach(input logic [15:0] cur,
                                             input logic [15:0] goal,
                                             input logic [15:0] stp);
        logic [15:0] res;
        res = goal;
        if (cur < goal && (goal - cur) > stp) begin
            res = cur + stp;
        end else if (cur > goal && (cur - goal) > stp) begin
            res = cur - stp;
        end
        return res;
    endfunction : approach

    // Sense minus reference, then multiplied by gain in 8.8 fixed point
    function automatic logic signed [15:0] scale_iout(input logic [SW-1:0] sense,
                                                      input logic [SW-1:0] vref,
                                                      input logic [15:0]   gain);
        logic signed [SW:0]    diff;
        logic signed [SW+17:0] prod;
        diff = $signed({1'b0, sense}) - $signed({1'b0, vref});
        prod = diff * $signed({1'b0, gain});
        return prod[23:8];
    endfunction : scale_iout

    function automatic logic [15:0] clamp_iout(input logic signed [19:0] v);
        logic [15:0] res;
        if (v < IOUT_MIN) begin
            res = IOUT_MIN;
        end else if (v > IOUT_MAX) begin
            res = IOUT_MAX;
        end else begin
            res = v[15:0];
        end
        return res;
    endfunction : clamp_iout

    function automatic logic margin_ok(input logic [3:0] code);
        return code == MARGIN_NONE || code == MARGIN_LOW_ACT || code == MARGIN_LOW_IGN ||
               code == MARGIN_HIGH_ACT || code == MARGIN_HIGH_IGN;
    endfunction : margin_ok

    assign pg = s.page[0];
    assign pwm_edge = s.pwm_s2 & ~s.pwm_prev;

    always_comb begin
        next = s;
        next.rdata = '0;
        next.tick = 1'b0;
        sel_t = '0;
        eff = '0;
        rise_step = '0;
        fall_step = '0;
        vprod = '0;
        scaled = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            eff_raw[c] = '0;
            sum_i[c] = '0;
            sum_o[c] = '0;
        end

        if (s.tick_cnt >= 16'(TICK_COUNT - 1)) begin
            next.tick_cnt = '0;
            next.tick = 1'b1;
        end else begin
            next.tick_cnt = s.tick_cnt + 16'h0001;
        end
        next.pwm_s1 = pwm_order0;
        next.pwm_s2 = s.pwm_s1;
        next.pwm_prev = s.pwm_s2;

        // Output current telemetry, one shared gain per channel
        for (int c = 0; c < NUM_CH; c++) begin
            for (int p = 0; p < NPH; p++) begin
                scaled = scale_iout(phase_current_sense_input[c*NPH+p], vref_sample,
                                    s.cfg[c][CFG_CAL_GAIN]);
                next.iphase[c][p] = clamp_iout(20'(scaled) +
                                               20'($signed(s.cal_off[c][p])));
                if (s.cfg[c][CFG_PH_ACTIVE][p]) begin
                    sum_i[c] = sum_i[c] + 20'(scaled);
                    sum_o[c] = sum_o[c] + 20'($signed(s.cal_off[c][p]));
                end
            end
            next.itotal[c] = 16'(sum_i[c] + sum_o[c]);
        end

        // Voltage target per channel
        for (int c = 0; c < NUM_CH; c++) begin
            case (s.operation[c][MARGIN_MSB:MARGIN_LSB])
                MARGIN_LOW_ACT, MARGIN_LOW_IGN: begin
                    sel_t[c] = s.cfg[c][CFG_MARGIN_LOW];
                end
                MARGIN_HIGH_ACT, MARGIN_HIGH_IGN: begin
                    sel_t[c] = s.cfg[c][CFG_MARGIN_HIGH];
                end
                default: begin
                    sel_t[c] = s.cfg[c][CFG_VOUT_CMD];
                end
            endcase
            next.fault_en[c] = !(s.operation[c][MARGIN_MSB:MARGIN_LSB] == MARGIN_LOW_IGN ||
                                 s.operation[c][MARGIN_MSB:MARGIN_LSB] == MARGIN_HIGH_IGN);
            eff_raw[c] = $signed({2'b00, sel_t[c]}) +
                         $signed({{2{s.cfg[c][CFG_TRIM][15]}}, s.cfg[c][CFG_TRIM]});
            if (eff_raw[c] > $signed({2'b00, s.cfg[c][CFG_VOUT_MAX]})) begin
                eff[c] = s.cfg[c][CFG_VOUT_MAX];
            end else if (eff_raw[c] < $signed({2'b00, s.cfg[c][CFG_VOUT_MIN]})) begin
                eff[c] = s.cfg[c][CFG_VOUT_MIN];
            end else if (eff_raw[c] < 18'sd0) begin
                eff[c] = '0;
            end else begin
                eff[c] = eff_raw[c][15:0];
            end
            rise_step[c] = (s.cfg[c][CFG_TON_RISE] == 16'h0000) ? eff[c] :
                           eff[c] / s.cfg[c][CFG_TON_RISE];
            fall_step[c] = (s.cfg[c][CFG_TOFF_FALL] == 16'h0000) ? s.present[c] :
                           s.present[c] / s.cfg[c][CFG_TOFF_FALL];
            if (rise_step[c] == 16'h0000) begin
                rise_step[c] = 16'h0001;
            end
            if (fall_step[c] == 16'h0000) begin
                fall_step[c] = 16'h0001;
            end

            case (s.st[c])
                CH_OFF: begin
                    next.present[c] = '0;
                    if (s.operation[c][OP_ON_BIT]) begin
                        next.step[c] = rise_step[c];
                        next.st[c] = CH_RISE;
                    end
                end
                CH_RISE: begin
                    if (!s.operation[c][OP_ON_BIT]) begin
                        next.step[c] = fall_step[c];
                        next.st[c] = CH_FALL;
                    end else if (s.tick) begin
                        next.present[c] = approach(s.present[c], eff[c], s.step[c]);
                        if (next.present[c] == eff[c]) begin
                            next.st[c] = CH_ON;
                        end
                    end
                end
                CH_ON: begin
                    if (!s.operation[c][OP_ON_BIT]) begin
                        next.step[c] = fall_step[c];
                        next.st[c] = CH_FALL;
                    end else if (s.tick) begin
                        next.present[c] = approach(s.present[c], eff[c],
                                                   s.cfg[c][CFG_TRANS_RATE]);
                    end
                end
                CH_FALL: begin
                    if (s.operation[c][OP_ON_BIT]) begin
                        next.step[c] = rise_step[c];
                        next.st[c] = CH_RISE;
                    end else if (s.tick) begin
                        next.present[c] = approach(s.present[c], 16'h0000, s.step[c]);
                        if (next.present[c] == 16'h0000) begin
                            next.st[c] = CH_OFF;
                        end
                    end
                end
                default: begin
                    next.st[c] = CH_OFF;
                end
            endcase

            // Transition load line and its recovery
            next.moving[c] = (s.st[c] == CH_ON) && (s.present[c] != eff[c]);
            if (s.st[c] != CH_ON) begin
                next.dyn[c] = 1'b0;
                next.rec_cnt[c] = '0;
            end else if (s.present[c] != eff[c]) begin
                next.dyn[c] = 1'b1;
                next.dir_up[c] = eff[c] > s.present[c];
                next.rec_cnt[c] = '0;
            end else if (s.dyn[c]) begin
                if (s.rec_cnt[c] >= s.cfg[c][CFG_REC_DELAY]) begin
                    next.dyn[c] = 1'b0;
                end else if (pwm_edge[c]) begin
                    next.rec_cnt[c] = s.rec_cnt[c] + 16'h0001;
                end
            end
            if (s.dyn[c]) begin
                next.ll[c] = s.dir_up[c] ? s.cfg[c][CFG_LL_UP] : s.cfg[c][CFG_LL_DOWN];
                next.llofs[c] = s.dir_up[c] ? s.cfg[c][CFG_OFS_UP] : s.cfg[c][CFG_OFS_DOWN];
            end else begin
                next.ll[c] = s.cfg[c][CFG_LL_NOM];
                next.llofs[c] = s.cfg[c][CFG_OFS_NOM];
            end
            vprod[c] = s.present[c] * s.cfg[c][CFG_SCALE_LOOP];
            next.vout[c] = vprod[c][23:8];
        end

        // Register port
        if (reg_write) begin
            if (reg_addr < CFG_N_A) begin
                next.cfg[pg][reg_addr[4:0]] = reg_wdata;
            end
            case (reg_addr)
                REG_PAGE: begin
                    next.page = reg_wdata[7:0];
                end
                REG_PHASE: begin
                    next.phase = reg_wdata[7:0];
                end
                REG_OPERATION: begin
                    if (margin_ok(reg_wdata[MARGIN_MSB:MARGIN_LSB])) begin
                        next.operation[pg] = reg_wdata[7:0];
                    end else begin
                        next.bad_margin[pg] = 1'b1;
                    end
                end
                REG_CAL_OFFSET: begin
                    if (s.phase < 8'(NPH)) begin
                        next.cal_off[pg][s.phase[PW-1:0]] = reg_wdata;
                    end
                end
                REG_STATUS: begin
                    next.bad_margin[pg] = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            if (reg_addr < CFG_N_A) begin
                next.rdata = s.cfg[pg][reg_addr[4:0]];
            end
            case (reg_addr)
                REG_PAGE:      next.rdata = {8'h00, s.page};
                REG_PHASE:     next.rdata = {8'h00, s.phase};
                REG_OPERATION: next.rdata = {8'h00, s.operation[pg]};
                REG_CAL_OFFSET: begin
                    if (s.phase < 8'(NPH)) begin
                        next.rdata = s.cal_off[pg][s.phase[PW-1:0]];
                    end
                end
                REG_READ_IOUT: begin
                    // Only output current has a calibration stage
                    if (s.phase == PHASE_TOTAL) begin
                        next.rdata = s.itotal[pg];
                    end else if (s.phase < 8'(NPH)) begin
                        next.rdata = s.iphase[pg][s.phase[PW-1:0]];
                    end
                end
                REG_STATUS: begin
                    next.rdata = {10'h000, s.bad_margin[pg], s.fault_en[pg], s.dyn[pg],
                                  s.moving[pg], s.st[pg]};
                end
                REG_PRESENT:   next.rdata = s.present[pg];
                default: begin
                end
            endcase
        end

        if (reset) begin
            next = '0;
            for (int c = 0; c < NUM_CH; c++) begin
                next.st[c] = CH_OFF;
                next.cfg[c][CFG_VOUT_MAX] = RST_VOUT_MAX;
                next.cfg[c][CFG_SCALE_LOOP] = RST_SCALE;
                next.cfg[c][CFG_CAL_GAIN] = RST_GAIN;
                next.cfg[c][CFG_TON_RISE] = RST_TON_RISE;
                next.cfg[c][CFG_TOFF_FALL] = RST_TOFF_FALL;
                next.cfg[c][CFG_TRANS_RATE] = RST_TRANS_RATE;
                next.cfg[c][CFG_PH_ACTIVE] = RST_PH_ACTIVE;
                next.fault_en[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        s <= next;
    end

    assign reg_rdata = s.rdata;
    assign vout_target = s.vout;
    assign fault_detect_enable = s.fault_en;
    assign loadline = s.ll;
    assign loadline_offset = s.llofs;
    assign dynamic_voltage_move = s.dyn;

    // Checks on channel 0, total current read on the paged channel
    logic [15:0] vscaled0;
    logic [15:0] itotal_pg;
    assign vscaled0 = vprod[0][23:8];
    assign itotal_pg = s.itotal[pg];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_clamp_limits: assert property (s.cfg[0][CFG_VOUT_MIN] <= s.cfg[0][CFG_VOUT_MAX] |->
        eff[0] <= s.cfg[0][CFG_VOUT_MAX] && eff[0] >= s.cfg[0][CFG_VOUT_MIN])
        else $error("target outside limits");
    chk_trim_offset: assert property (eff_raw[0] >= $signed({2'b00, s.cfg[0][CFG_VOUT_MIN]}) &&
        eff_raw[0] <= $signed({2'b00, s.cfg[0][CFG_VOUT_MAX]}) && eff_raw[0] >= 18'sd0 |->
        eff[0] == 16'(sel_t[0] + s.cfg[0][CFG_TRIM]))
        else $error("trim not added to target");
    chk_margin_low: assert property (s.operation[0][MARGIN_MSB:MARGIN_LSB] == MARGIN_LOW_ACT |->
        sel_t[0] == s.cfg[0][CFG_MARGIN_LOW])
        else $error("margin low not selected");
    chk_fault_ignore: assert property (
        s.operation[0][MARGIN_MSB:MARGIN_LSB] == MARGIN_HIGH_IGN ##1
        s.operation[0][MARGIN_MSB:MARGIN_LSB] == MARGIN_HIGH_IGN |-> !s.fault_en[0])
        else $error("fault detection not disabled");
    chk_invalid_margin: assert property (reg_write && reg_addr == REG_OPERATION && !pg &&
        !margin_ok(reg_wdata[MARGIN_MSB:MARGIN_LSB]) |=> $stable(s.operation[0]) && s.bad_margin[0])
        else $error("invalid margin code accepted");
    chk_slew_rate: assert property ($past(s.st[0]) == CH_ON && s.st[0] == CH_ON |->
        ((s.present[0] > $past(s.present[0])) ? s.present[0] - $past(s.present[0]) :
        $past(s.present[0]) - s.present[0]) <= $past(s.cfg[0][CFG_TRANS_RATE]))
        else $error("slew faster than transition rate");
    chk_no_tick_move: assert property (s.st[0] == CH_ON && !s.tick |=> $stable(s.present[0]))
        else $error("target moved without tick");
    chk_dyn_start: assert property (s.moving[0] && s.st[0] == CH_ON |-> s.dyn[0])
        else $error("transition load line not applied");
    chk_recovery_hold: assert property (s.dyn[0] && s.st[0] == CH_ON && s.present[0] == eff[0] &&
        s.rec_cnt[0] < s.cfg[0][CFG_REC_DELAY] |=> s.dyn[0])
        else $error("load line restored before delay");
    chk_scale_loop: assert property (1'b1 |=> s.vout[0] == $past(vscaled0))
        else $error("scale factor not applied");
    chk_iout_total: assert property (reg_read && reg_addr == REG_READ_IOUT && s.phase == PHASE_TOTAL
        |=> reg_rdata == $past(itotal_pg))
        else $error("total current read wrong");
    chk_iout_range: assert property ($signed(s.iphase[0][0]) >= IOUT_MIN &&
        $signed(s.iphase[0][0]) <= IOUT_MAX)
        else $error("phase current out of span");
endmodule : vout_target_margin_telemetry

// *** verif/pwm_source.sv ***
// Order-0 PWM source that stands in for the switching power stage
module pwm_source (
    input  wire logic       run,
    output logic      [1:0] pwm
);
    timeunit 1ns;
    timeprecision 100ps;
    // Edges only while converting, 160 ns period
    initial begin
        pwm = 2'h0;
        forever #80 pwm = run ? ~pwm : 2'h0;
    end
endmodule : pwm_source

// *** verif/tb.sv ***
// Register-level bench for the voltage target and current telemetry block
module tb import vout_telemetry_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic                     clock = 1'b0, reset = 1'b1, run = 1'b0;
    logic                     reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]               reg_addr = 8'h00;
    logic [15:0]              reg_wdata = 16'h0000, reg_rdata, prev;
    logic [1:0]               pwm_order0, fault_detect_enable, dynamic_voltage_move;
    logic [1:0][15:0]         vout_target, loadline, loadline_offset;
    logic [7:0][11:0]         sense = {{5{12'h620}}, 12'hdd0, 12'h620, 12'h620};
    logic [11:0]              vref_sample = 12'h600;
    int                       mismatches = 0, tests_run = 0;
    logic [4:0]               cfg_a [12] = '{CFG_VOUT_CMD, CFG_MARGIN_LOW, CFG_MARGIN_HIGH,
        CFG_TRANS_RATE, CFG_SCALE_LOOP, CFG_LL_NOM, CFG_LL_UP, CFG_LL_DOWN, CFG_REC_DELAY,
        CFG_OFS_NOM, CFG_OFS_UP, CFG_OFS_DOWN};
    logic [15:0]              cfg_d [12] = '{16'h0100, 16'h0080, 16'h0180, 16'h0010,
        16'h0200, 16'h0011, 16'h0022, 16'h0033, 16'h0002, 16'h0044, 16'h0055, 16'h0066};
    logic [3:0]               codes [5] = '{MARGIN_NONE, MARGIN_LOW_ACT, MARGIN_LOW_IGN,
        MARGIN_HIGH_ACT, MARGIN_HIGH_IGN};
    logic [15:0]              goals [5] = '{16'h0100, 16'h0080, 16'h0080, 16'h0180, 16'h0180};

    vout_target_margin_telemetry #(.TICK_COUNT(4)) u_vout_target_margin_telemetry (.clock,
        .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pwm_order0,
        .phase_current_sense_input(sense), .vref_sample, .vout_target, .fault_detect_enable,
        .loadline, .loadline_offset, .dynamic_voltage_move);
    pwm_source u_pwm_source (.run(run), .pwm(pwm_order0));

    initial forever #5 clock = ~clock;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        rd(REG_STATUS, 16'h0010);
        rd({3'h0, CFG_VOUT_MAX}, 16'h157c);
        rd(8'h30, 16'h0000);
        $display("reset values done");
        wr(REG_PHASE, 16'h0000);
        wr(REG_CAL_OFFSET, 16'h0005);
        rd(REG_READ_IOUT, 16'h0025);
        wr(REG_PHASE, 16'h0002);
        rd(REG_READ_IOUT, 16'h0460);
        wr(REG_PHASE, 16'h00ff);
        rd(REG_READ_IOUT, 16'h0835);
        wr({3'h0, CFG_CAL_GAIN}, 16'h0200);
        rd(REG_READ_IOUT, 16'h1065);
        wr({3'h0, CFG_PH_ACTIVE}, 16'h0001);
        rd(REG_READ_IOUT, 16'h0045);
        wr({3'h0, CFG_PH_ACTIVE}, 16'h000f);
        $display("current telemetry done");
        wr(REG_PAGE, 16'h0000);
        for (int i = 0; i < 12; i++) wr({3'h0, cfg_a[i]}, cfg_d[i]);
        wr(REG_OPERATION, 16'h0080);
        run <= 1'b1;
        repeat (120) @(posedge clock);
        rd(8'h26, 16'h0100);
        rd(REG_STATUS, 16'h0012);
        prev = 16'h0100;
        for (int i = 0; i < 5; i++) begin
            wr(REG_OPERATION, {8'h00, 2'b10, codes[i], 2'b00});
            repeat (10) @(posedge clock);
            #1;
            chk(loadline[0], goals[i] > prev ? 16'h0022 : goals[i] < prev ? 16'h0033 : 16'h0011);
            chk(loadline_offset[0], goals[i] > prev ? 16'h0055 :
                goals[i] < prev ? 16'h0066 : 16'h0044);
            chk({15'h0, dynamic_voltage_move[0]}, {15'h0, goals[i] != prev});
            repeat (120) @(posedge clock);
            rd(8'h26, goals[i]);
            chk(vout_target[0], goals[i] << 1);
            chk({15'h0, fault_detect_enable[0]}, {15'h0, codes[i][1:0] != 2'b10});
            chk(loadline[0], 16'h0011);
            chk(loadline_offset[0], 16'h0044);
            chk({15'h0, dynamic_voltage_move[0]}, 16'h0000);
            prev = goals[i];
        end
        $display("margin steps done");
        wr({3'h0, CFG_TRIM}, 16'h0020);
        repeat (120) @(posedge clock);
        rd(8'h26, 16'h01a0);
        wr({3'h0, CFG_VOUT_MAX}, 16'h0150);
        repeat (120) @(posedge clock);
        rd(8'h26, 16'h0150);
        wr(REG_OPERATION, 16'h008c);
        rd(REG_STATUS, 16'h0022);
        rd(8'h26, 16'h0150);
        wr(REG_OPERATION, 16'h0000);
        repeat (120) @(posedge clock);
        rd(REG_STATUS, 16'h0030);
        $display("limits and soft off done");
        end_sim();
    end
endmodule : tb
